/* File: include/pm_consts.vh */
`ifndef PM_CONSTS_VH
`define PM_CONSTS_VH

// Register offset within the bank
`define PMC_OFFSET 8'h08
`define PMC_WIDTH 16

// Field positions
`define PMC_FLAG_BIT 15
`define PMC_ENABLE_BIT 8
`define PMC_KEEP_CTX_BIT 3
`define PMC_LEVEL_HI 1
`define PMC_LEVEL_LO 0

// Reset values
`define PMC_FLAG_RST 1'b0
`define PMC_ENABLE_RST 1'b0
`define PMC_LEVEL_RST 2'h0

// Power level encodings
`define LEVEL_D0 2'h0
`define LEVEL_D1 2'h1
`define LEVEL_D2 2'h2
`define LEVEL_D3HOT 2'h3

// Length of the internal soft reset pulse, in clock cycles
`define SOFT_RST_CYCLES 4'h4

`endif

/* File: verilog/soft_reset_pulse.v */
`timescale 1ns/1ps
`include "pm_consts.vh"

module soft_reset_pulse #(
  parameter CW = 4
) (
  input wire clk, // 25 MHz clock
  input wire nrst, // Power-up reset, active low
  input wire trigger, // One-cycle start request
  input wire [CW-1:0] length, // Pulse length in cycles
  output reg pulse_r // High while the internal reset runs
);

  reg [CW-1:0] count_r;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count_r <= {CW{1'b0}};
      pulse_r <= 1'b0;
    end
    else if (trigger)
    begin
      count_r <= length;
      pulse_r <= 1'b1;
    end
    else if (count_r > {{(CW-1){1'b0}}, 1'b1})
    begin
      count_r <= count_r - {{(CW-1){1'b0}}, 1'b1};
    end
    else
    begin
      count_r <= {CW{1'b0}};
      pulse_r <= 1'b0;
    end
  end

endmodule

/* File: verilog/power_mgmt_ctrl_status.v */
// Function
// - A detected power-management event sets the wake event flag and, if enabled, drives the pin.
// - The wake event flag clears only on power-up reset or a host write of one to it.
// - Hardware and software resets leave the wake event flag untouched.
// - When the wake event flag clears, the event pin is released.
// - The event pin is asserted only while the wake pin enable bit is set.
// - The wake pin enable bit resets to zero on power-up and survives software reset.
// - With the keep-context bit set, a software D3hot to D0 move causes no internal reset.
// - With the keep-context bit clear, a software D3hot to D0 move runs an internal reset.
// - A system or bus reset from D3hot always returns to uninitialised D0, keeping event context.
// - The keep-context bit is read-only and loaded from the serial EEPROM configuration bit.
// - The host writes the two-bit power level field with 00 D0, 01 D1, 10 D2, 11 D3hot.
// - Reading the power level field returns the present power level.
`timescale 1ns/1ps
`include "pm_consts.vh"

module power_mgmt_ctrl_status #(
  parameter AW = 8, // Register address width
  parameter DW = `PMC_WIDTH // Register data width
) (
  input wire clk, // 25 MHz clock
  input wire nrst, // Power-up reset, active low
  input wire hw_rst, // Hardware reset, active high level
  input wire sw_rst, // Software reset, active high level
  input wire sys_rst, // System or bus segment reset, active high
  input wire reg_sel, // Register access strobe
  input wire reg_wr, // 1 write, 0 read
  input wire [AW-1:0] reg_addr, // Register byte offset in bank
  input wire [DW-1:0] reg_wdata, // Write data
  input wire [1:0] reg_be, // Byte enables, bit 1 upper byte
  output reg [DW-1:0] reg_rdata, // Read data, registered
  input wire wake_event, // Power-management event detected, pulse
  input wire eeprom_load, // EEPROM config word valid strobe
  input wire eeprom_keep_ctx, // Keep-context bit from EEPROM
  output reg wake_event_out_n, // Event pin, active low
  output reg internal_rst, // Internal soft reset to the core
  output reg [1:0] power_level // Present power level to the core
);

  // Power levels handled as a small state machine
  localparam [1:0] ST_D0 = `LEVEL_D0;
  localparam [1:0] ST_D1 = `LEVEL_D1;
  localparam [1:0] ST_D2 = `LEVEL_D2;
  localparam [1:0] ST_D3HOT = `LEVEL_D3HOT;

  reg wake_event_flag_r;
  reg wake_event_flag_nxt;
  reg wake_pin_enable_r;
  reg wake_pin_enable_nxt;
  reg keep_context_cfg_bit_r;
  reg keep_context_cfg_bit_nxt;
  reg [1:0] power_level_field_r;
  reg [1:0] power_level_field_nxt;
  reg start_soft_rst;
  reg wake_pin_active;
  reg [DW-1:0] reg_rdata_nxt;
  wire soft_rst_busy;
  wire hit;
  wire rd_hit;
  wire rd_miss;
  wire wr_lo;
  wire wr_hi;
  wire flag_clr_req;
  wire enable_wr_val;
  wire [1:0] level_wr_val;
  wire any_level_rst;
  wire [DW-1:0] read_word;

  assign hit = reg_sel && (reg_addr == `PMC_OFFSET);
  assign rd_hit = hit && !reg_wr;
  assign rd_miss = reg_sel && !reg_wr && !hit;
  assign wr_lo = hit && reg_wr && reg_be[0];
  assign wr_hi = hit && reg_wr && reg_be[1];

  // Field slices of the write word
  assign flag_clr_req = wr_hi && reg_wdata[`PMC_FLAG_BIT];
  assign enable_wr_val = reg_wdata[`PMC_ENABLE_BIT];
  assign level_wr_val = reg_wdata[`PMC_LEVEL_HI:`PMC_LEVEL_LO];
  assign any_level_rst = sys_rst || hw_rst;

  // Flag: set wins over a clearing write so no event is lost
  always @*
  begin
    wake_event_flag_nxt = wake_event_flag_r;
    if (flag_clr_req)
    begin
      wake_event_flag_nxt = 1'b0;
    end
    if (wake_event)
    begin
      wake_event_flag_nxt = 1'b1;
    end
  end

  // Only power-up reset touches the flag; hw/sw/sys resets ignored here
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wake_event_flag_r <= `PMC_FLAG_RST;
    end
    else
    begin
      wake_event_flag_r <= wake_event_flag_nxt;
    end
  end

  always @*
  begin
    wake_pin_enable_nxt = wake_pin_enable_r;
    if (wr_hi)
    begin
      wake_pin_enable_nxt = enable_wr_val;
    end
  end

  // Enable survives software reset: that input is not looked at
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wake_pin_enable_r <= `PMC_ENABLE_RST;
    end
    else
    begin
      wake_pin_enable_r <= wake_pin_enable_nxt;
    end
  end

  // Pin follows next flag value so it moves in the same cycle the flag does
  always @*
  begin
    wake_pin_active = 1'b0;
    if (wake_pin_enable_nxt)
    begin
      wake_pin_active = wake_event_flag_nxt;
    end
  end

  // Idles high so a released pin never reads as an event
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wake_event_out_n <= 1'b1;
    end
    else
    begin
      wake_event_out_n <= ~wake_pin_active;
    end
  end

  // Captured from EEPROM; host writes cannot reach it
  always @*
  begin
    keep_context_cfg_bit_nxt = keep_context_cfg_bit_r;
    if (eeprom_load)
    begin
      keep_context_cfg_bit_nxt = eeprom_keep_ctx;
    end
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      keep_context_cfg_bit_r <= 1'b0;
    end
    else
    begin
      keep_context_cfg_bit_r <= keep_context_cfg_bit_nxt;
    end
  end

  // Hardware and system resets outrank a host write landing in the same cycle
  always @*
  begin
    power_level_field_nxt = power_level_field_r;
    start_soft_rst = 1'b0;
    case (power_level_field_r)
      ST_D0:
      begin
        if (wr_lo)
        begin
          power_level_field_nxt = level_wr_val;
        end
      end
      ST_D1:
      begin
        if (wr_lo)
        begin
          power_level_field_nxt = level_wr_val;
        end
      end
      ST_D2:
      begin
        if (wr_lo)
        begin
          power_level_field_nxt = level_wr_val;
        end
      end
      ST_D3HOT:
      begin
        if (wr_lo)
        begin
          power_level_field_nxt = level_wr_val;
          if (level_wr_val == ST_D0)
          begin
            // Context survives only when the EEPROM bit asks for it
            start_soft_rst = ~keep_context_cfg_bit_r;
          end
        end
      end
      default:
      begin
        power_level_field_nxt = ST_D0;
      end
    endcase
    if (any_level_rst)
    begin
      power_level_field_nxt = ST_D0;
      start_soft_rst = 1'b0;
    end
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      power_level_field_r <= `PMC_LEVEL_RST;
    end
    else
    begin
      power_level_field_r <= power_level_field_nxt;
    end
  end

  soft_reset_pulse #(
    .CW(4)
  ) u_soft_rst (
    .clk(clk),
    .nrst(nrst),
    .trigger(start_soft_rst),
    .length(`SOFT_RST_CYCLES),
    .pulse_r(soft_rst_busy)
  );

  // Context loss reaches the core through this pulse; event context kept
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      internal_rst <= 1'b0;
    end
    else
    begin
      internal_rst <= soft_rst_busy;
    end
  end

  // One cycle behind the field, so the core sees a clean registered level
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      power_level <= `PMC_LEVEL_RST;
    end
    else
    begin
      power_level <= power_level_field_r;
    end
  end

  assign read_word = {wake_event_flag_r, 6'h00, wake_pin_enable_r, 4'h0,
                      keep_context_cfg_bit_r, 1'b0, power_level_field_r};

  // Read data holds until the next read; misses return zero
  always @*
  begin
    reg_rdata_nxt = reg_rdata;
    if (rd_hit)
    begin
      reg_rdata_nxt = read_word;
    end
    else if (rd_miss)
    begin
      reg_rdata_nxt = {DW{1'b0}};
    end
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= {DW{1'b0}};
    end
    else
    begin
      reg_rdata <= reg_rdata_nxt;
    end
  end

endmodule

/* File: tb/ee_model.sv */
`timescale 1ns/1ps
module ee_model(
  input wire clk, // Bench clock
  input wire nrst, // Power-up reset
  input wire cfg, // Stored keep-context bit
  output reg load, // Reload strobe
  output wire bit_o // Bit handed to the block
);
  reg last_r;
  assign bit_o = cfg;
  // Any change reloads, like a fresh EEPROM read
  always @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      load <= 1'b0;
      last_r <= 1'b1;
    end
    else
    begin
      load <= cfg != last_r;
      last_r <= cfg;
    end
endmodule

/* File: tb/pm_chk_asserts.sv */
`timescale 1ns/1ps
module pm_chk(input wire clk, input wire nrst, input wire hw_rst, input wire sw_rst,
  input wire sys_rst, input wire reg_sel, input wire reg_wr, input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata, input wire [1:0] reg_be, input wire [15:0] reg_rdata,
  input wire wake_event, input wire wake_event_out_n, input wire internal_rst,
  input wire [1:0] power_level);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire wr = reg_sel && reg_wr && reg_addr == 8'h08;
  wire rd = reg_sel && !reg_wr;
  sequence s_pulse;
    internal_rst [*4] ##1 !internal_rst;
  endsequence
  AST_CLR: assert property (wr && reg_be[1] && reg_wdata[15] && !wake_event |=> wake_event_out_n)
    else $error("pin kept");
  AST_SET: assert property ($fell(wake_event_out_n) |-> $past(wake_event || wr))
    else $error("pin no cause");
  AST_LVL: assert property (wr && reg_be[0] && !hw_rst && !sys_rst |=> ##1 power_level == $past(reg_wdata[1:0], 2))
    else $error("level");
  AST_SYS: assert property (hw_rst || sys_rst |=> ##1 power_level == 2'h0)
    else $error("sys level");
  AST_PULSE: assert property ($rose(internal_rst) |-> s_pulse)
    else $error("pulse");
  AST_SW: assert property (sw_rst && !wake_event && !reg_sel |=> $stable(wake_event_out_n))
    else $error("sw pin");
  AST_MAP: assert property (rd && reg_addr != 8'h08 |=> reg_rdata == 16'h0000)
    else $error("unmapped");
  AST_RSV: assert property (rd |=> reg_rdata[14:9] == 6'h00 && reg_rdata[7:4] == 4'h0)
    else $error("reserved");
endmodule
bind power_mgmt_ctrl_status pm_chk pm_chk_inst(.*);

/* File: tb/power_mgmt_ctrl_status_tb_top.sv */
`timescale 1ns/1ps
module power_mgmt_ctrl_status_tb_top;
  reg clk, nrst, hw_rst, sw_rst, sys_rst, reg_sel, reg_wr, wake_event, keep_cfg;
  reg [7:0] reg_addr;
  reg [15:0] reg_wdata;
  reg [1:0] reg_be;
  wire [15:0] reg_rdata;
  wire [1:0] power_level;
  wire wake_event_out_n, internal_rst, eeprom_load, eeprom_keep_ctx;
  integer fails, num_checks, i;
  reg [33:0] rows [0:4];
  power_mgmt_ctrl_status power_mgmt_ctrl_status_inst(.*);
  ee_model ee_model_inst(.clk, .nrst, .cfg(keep_cfg), .load(eeprom_load),
    .bit_o(eeprom_keep_ctx));
  task stop_test;
    begin
      if (fails == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [63:0] n, input [15:0] s, input [15:0] e);
    begin
      num_checks = num_checks + 1;
      if (s !== e)
      begin
        fails = fails + 1;
        $display("CHECK FAILED %0s exp %h got %h", n, e, s);
      end
    end
  endtask
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task acc(input w, input [7:0] a, input [15:0] d, input [1:0] b);
    begin
      {reg_sel, reg_wr, reg_addr, reg_wdata, reg_be} = {1'b1, w, a, d, b};
      tick;
      reg_sel = 1'b0;
      tick;
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #20000;
    fails = fails + 1;
    stop_test;
  end
  initial
  begin
    {fails, num_checks, nrst, hw_rst, sw_rst, sys_rst, wake_event, keep_cfg} = 0;
    acc(1'b0, 8'h08, 16'h0000, 2'h0);
    rows[0] = {16'h0101, 2'h3, 16'h0101};
    rows[1] = {16'h0002, 2'h1, 16'h0102};
    rows[2] = {16'h0003, 2'h1, 16'h0103};
    rows[3] = {16'h0000, 2'h1, 16'h0100};
    rows[4] = {16'h8000, 2'h2, 16'h0000};
    repeat (12) tick;
    nrst = 1'b1;
    for (i = 0; i < 5; i = i + 1)
    begin
      acc(1'b1, 8'h08, rows[i][33:18], rows[i][17:16]);
      acc(1'b0, 8'h08, 16'h0000, 2'h0);
      chk("row", reg_rdata, rows[i][15:0]);
      chk("row_lvl", {14'h0000, power_level}, {14'h0000, rows[i][1:0]});
    end
    repeat (6) tick;
    wake_event = 1'b1;
    tick;
    wake_event = 1'b0;
    tick;
    chk("pin_off", wake_event_out_n, 16'h0001);
    acc(1'b0, 8'h08, 16'h0000, 2'h0);
    chk("flag", reg_rdata, 16'h8000);
    acc(1'b1, 8'h08, 16'h0100, 2'h2);
    chk("pin_on", wake_event_out_n, 16'h0000);
    sw_rst = 1'b1;
    tick;
    {sw_rst, hw_rst} = 2'h1;
    tick;
    {hw_rst, sys_rst} = 2'h1;
    tick;
    sys_rst = 1'b0;
    acc(1'b1, 8'h08, 16'h0100, 2'h2);
    chk("pin_kept", wake_event_out_n, 16'h0000);
    acc(1'b0, 8'h20, 16'h0000, 2'h0);
    chk("unmapped", reg_rdata, 16'h0000);
    acc(1'b1, 8'h08, 16'h8100, 2'h2);
    chk("pin_clr", wake_event_out_n, 16'h0001);
    keep_cfg = 1'b1;
    repeat (3) tick;
    acc(1'b1, 8'h08, 16'h0003, 2'h1);
    acc(1'b1, 8'h08, 16'h0000, 2'h1);
    repeat (6)
    begin
      chk("no_rst", internal_rst, 16'h0000);
      tick;
    end
    acc(1'b0, 8'h08, 16'h0000, 2'h0);
    chk("keep", reg_rdata, 16'h0108);
    acc(1'b1, 8'h08, 16'h0002, 2'h1);
    chk("lvl_d2", {14'h0000, power_level}, 16'h0002);
    hw_rst = 1'b1;
    tick;
    hw_rst = 1'b0;
    tick;
    chk("lvl_hw", {14'h0000, power_level}, 16'h0000);
    keep_cfg = 1'b0;
    repeat (3) tick;
    acc(1'b1, 8'h08, 16'h0003, 2'h1);
    acc(1'b1, 8'h08, 16'h0000, 2'h1);
    chk("srst_on", internal_rst, 16'h0001);
    repeat (3) tick;
    chk("srst_end", internal_rst, 16'h0001);
    tick;
    chk("srst_off", internal_rst, 16'h0000);
    stop_test;
  end
endmodule
